// *** src/scir_consts.vh ***
`ifndef SCIR_CONSTS_VH
`define SCIR_CONSTS_VH
// ----------------------------------------
// Interrupt line indices
// ----------------------------------------
`define SCIR_INTA        2'd0
`define SCIR_INTB        2'd1
`define SCIR_INTC        2'd2
`define SCIR_INTD        2'd3
// ----------------------------------------
// Request kind codes
// ----------------------------------------
`define SCIR_KIND_W      3
`define SCIR_K_MEM       3'h0
`define SCIR_K_IO        3'h1
`define SCIR_K_CFG0      3'h2
`define SCIR_K_CFG1      3'h3
`define SCIR_K_MSG_ADDR  3'h4
`define SCIR_K_MSG_ID    3'h5
// ----------------------------------------
// Destination codes from the routing lookup
// ----------------------------------------
`define SCIR_DST_NONE    2'h0
`define SCIR_DST_UP      2'h1
`define SCIR_DST_B       2'h2
`define SCIR_DST_C       2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCIR_IRQ_RST     4'h0
`define SCIR_TAG_W       8
`define SCIR_TAG_RST     8'h00
// ----------------------------------------
// Message opcodes on the upstream message port
// ----------------------------------------
`define SCIR_MSG_ASSERT  1'b1
`define SCIR_MSG_DEASSERT 1'b0
`endif

// *** src/scir_irq_msg.v ***
`timescale 1ns/1ps
`include "scir_consts.vh"
// Turns aggregate transitions into one assert or deassert message at a time
module scir_irq_msg (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] agg,
    input  wire       msg_ready,
    output reg        msg_valid,
    output reg        msg_assert,
    output reg  [1:0] msg_line,
    output reg  [3:0] sent_state
);
    reg [3:0] diff;
    reg [1:0] pick;
    reg       found;
    integer   i;

    // ----------------------------------------
    // Lowest line whose reported state differs
    // ----------------------------------------
    always @* begin
        diff  = agg ^ sent_state;
        pick  = 2'd0;
        found = 1'b0;
        for (i = 3; i >= 0; i = i - 1) begin
            if (diff[i]) begin
                pick  = i[1:0];
                found = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid  <= 1'b0;
            msg_assert <= 1'b0;
            msg_line   <= 2'd0;
            sent_state <= `SCIR_IRQ_RST;
        end else if (msg_valid) begin
            if (msg_ready) begin
                msg_valid <= 1'b0;
            end
        end else if (found) begin
            // Rising aggregate gives assert, falling gives deassert
            msg_valid        <= 1'b1;
            msg_line         <= pick;
            msg_assert       <= agg[pick] ? `SCIR_MSG_ASSERT : `SCIR_MSG_DEASSERT;
            sent_state[pick] <= agg[pick];
        end
    end
endmodule // scir_irq_msg

// *** src/scir_ur_class.v ***
`timescale 1ns/1ps
`include "scir_consts.vh"
// Classifies one upstream request as supported or unsupported
module scir_ur_class (
    input  wire [2:0] kind,
    input  wire [4:0] dev_num,
    input  wire       to_downstream,
    input  wire       bridge_init,
    input  wire [1:0] dest,
    input  wire       hit_up_window,
    input  wire       hit_dn_window,
    input  wire       port_b_up,
    input  wire       port_c_up,
    input  wire       port_b_enable,
    input  wire       port_c_enable,
    input  wire       legacy_video_hit,
    input  wire       legacy_video_up,
    input  wire       legacy_video_b,
    input  wire       legacy_video_c,
    output reg        is_ur
);
    reg is_addr;
    reg dis_b;
    reg dis_c;

    always @* begin
        is_addr = (kind == `SCIR_K_MEM) || (kind == `SCIR_K_IO) || (kind == `SCIR_K_MSG_ADDR);
        dis_b   = !port_b_up || !port_b_enable;
        dis_c   = !port_c_up || !port_c_enable;
        is_ur   = 1'b0;
        if (kind == `SCIR_K_CFG0)
            is_ur = 1'b1;
        if (kind == `SCIR_K_CFG1 && to_downstream && dev_num != 5'h00)
            is_ur = 1'b1;
        if (kind == `SCIR_K_MSG_ADDR && !bridge_init)
            is_ur = 1'b1;
        if (is_addr && hit_up_window && !hit_dn_window)
            is_ur = 1'b1;
        if (is_addr && dest == `SCIR_DST_UP)
            is_ur = 1'b1;
        if (dest == `SCIR_DST_NONE)
            is_ur = 1'b1;
        if ((dest == `SCIR_DST_B && dis_b) || (dest == `SCIR_DST_C && dis_c))
            is_ur = 1'b1;
        if (legacy_video_hit && legacy_video_up && !legacy_video_b && !legacy_video_c && !hit_dn_window)
            is_ur = 1'b1;
    end
endmodule // scir_ur_class

// *** src/scir_core.v ***
`timescale 1ns/1ps
`include "scir_consts.vh"
// ----------------------------------------
// ----------------------------------------
module scir_core (
    input  wire        CLOCK,
    input  wire        RESET_N,
    input  wire [3:0]  IRQ_PORT_B,
    input  wire [3:0]  IRQ_PORT_C_EXT,
    input  wire [3:0]  IRQ_NTB_INTERNAL,
    input  wire        LINK_UP_B,
    input  wire        LINK_UP_C,
    output reg  [3:0]  SWITCH_STATUS_UPSTREAM,
    output reg  [3:0]  IRQ_STATE_PORT_A,
    output reg  [3:0]  IRQ_STATE_PORT_B,
    output reg  [3:0]  IRQ_STATE_PORT_C,
    output wire        IRQ_MSG_VALID,
    output wire        IRQ_MSG_ASSERT,
    output wire [1:0]  IRQ_MSG_LINE,
    input  wire        IRQ_MSG_READY,
    input  wire        REQ_VALID,
    input  wire [2:0]  REQ_KIND,
    input  wire        REQ_POSTED,
    input  wire [7:0]  REQ_TAG,
    input  wire [4:0]  REQ_DEV_NUM,
    input  wire        REQ_TO_DOWNSTREAM,
    input  wire [1:0]  REQ_DEST,
    input  wire        REQ_HIT_UP_WINDOW,
    input  wire        REQ_HIT_DN_WINDOW,
    input  wire        REQ_LEGACY_VIDEO_HIT,
    input  wire        BRIDGE_INIT,
    input  wire        MEMORY_ACCESS_ENABLE_B,
    input  wire        IO_ACCESS_ENABLE_B,
    input  wire        MEMORY_ACCESS_ENABLE_C,
    input  wire        IO_ACCESS_ENABLE_C,
    input  wire        LEGACY_VIDEO_DECODE_ENABLE_A,
    input  wire        LEGACY_VIDEO_DECODE_ENABLE_B,
    input  wire        LEGACY_VIDEO_DECODE_ENABLE_C,
    output reg         REQ_FORWARD,
    output reg         REQ_UR_DISCARD,
    output reg         UR_CPL_VALID,
    output reg  [7:0]  UR_CPL_TAG,
    input  wire        UR_CPL_READY,
    output reg         UR_CPL_DROPPED,
    output reg         UR_STATUS,
    input  wire        UR_STATUS_CLEAR,
    output reg         ERR_MSG_VALID,
    input  wire        ERR_MSG_READY
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [13:0] sync1_r;
    reg [13:0] sync2_r;
    wire [13:0] pins_in;

    assign pins_in = {IRQ_PORT_B, IRQ_PORT_C_EXT, IRQ_NTB_INTERNAL, LINK_UP_B, LINK_UP_C};

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_r <= 14'h0000;
            sync2_r <= 14'h0000;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
        end
    end

    wire [3:0] irq_b_s;
    wire [3:0] irq_c_ext_s;
    wire [3:0] irq_ntb_s;
    wire       link_b_s;
    wire       link_c_s;

    assign irq_b_s     = sync2_r[13:10];
    assign irq_c_ext_s = sync2_r[9:6];
    assign irq_ntb_s   = sync2_r[5:2];
    assign link_b_s    = sync2_r[1];
    assign link_c_s    = sync2_r[0];

    // ----------------------------------------
    // Interrupt aggregation
    // ----------------------------------------
    // Upstream bridge swizzle, line n of port C feeds line n+1
    function [3:0] scir_remap;
        input [3:0] pb;
        input [3:0] pc;
        begin
            scir_remap = pb | {pc[2:0], pc[3]};
        end
    endfunction

    reg [3:0] port_b_nxt;
    reg [3:0] port_c_nxt;
    reg [3:0] agg_nxt;

    always @* begin
        // Downstream bridges see only device zero so no remap here
        port_b_nxt = link_b_s ? irq_b_s : 4'h0;
        port_c_nxt = link_c_s ? (irq_c_ext_s | irq_ntb_s) : 4'h0;
        agg_nxt    = scir_remap(port_b_nxt, port_c_nxt);
    end

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ_STATE_PORT_B       <= `SCIR_IRQ_RST;
            IRQ_STATE_PORT_C       <= `SCIR_IRQ_RST;
            IRQ_STATE_PORT_A       <= `SCIR_IRQ_RST;
            SWITCH_STATUS_UPSTREAM <= `SCIR_IRQ_RST;
        end else begin
            IRQ_STATE_PORT_B       <= port_b_nxt;
            IRQ_STATE_PORT_C       <= port_c_nxt;
            IRQ_STATE_PORT_A       <= agg_nxt;
            SWITCH_STATUS_UPSTREAM <= agg_nxt;
        end
    end

    // ----------------------------------------
    // Interrupt message generation
    // ----------------------------------------
    scir_irq_msg u_irq_msg (
        .clk        (CLOCK),
        .rst_n      (RESET_N),
        .agg        (SWITCH_STATUS_UPSTREAM),
        .msg_ready  (IRQ_MSG_READY),
        .msg_valid  (IRQ_MSG_VALID),
        .msg_assert (IRQ_MSG_ASSERT),
        .msg_line   (IRQ_MSG_LINE),
        .sent_state ()
    );

    // ----------------------------------------
    // Unsupported request classification
    // ----------------------------------------
    wire is_ur;

    scir_ur_class u_ur_class (
        .kind             (REQ_KIND),
        .dev_num          (REQ_DEV_NUM),
        .to_downstream    (REQ_TO_DOWNSTREAM),
        .bridge_init      (BRIDGE_INIT),
        .dest             (REQ_DEST),
        .hit_up_window    (REQ_HIT_UP_WINDOW),
        .hit_dn_window    (REQ_HIT_DN_WINDOW),
        .port_b_up        (link_b_s),
        .port_c_up        (link_c_s),
        .port_b_enable    (MEMORY_ACCESS_ENABLE_B && IO_ACCESS_ENABLE_B),
        .port_c_enable    (MEMORY_ACCESS_ENABLE_C && IO_ACCESS_ENABLE_C),
        .legacy_video_hit (REQ_LEGACY_VIDEO_HIT),
        .legacy_video_up  (LEGACY_VIDEO_DECODE_ENABLE_A),
        .legacy_video_b   (LEGACY_VIDEO_DECODE_ENABLE_B),
        .legacy_video_c   (LEGACY_VIDEO_DECODE_ENABLE_C),
        .is_ur            (is_ur)
    );

    wire ur_event;
    wire ur_np;

    assign ur_event = REQ_VALID && is_ur;
    assign ur_np    = ur_event && !REQ_POSTED;

    // ----------------------------------------
    // Request outcome and completion slot
    // ----------------------------------------
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            REQ_FORWARD    <= 1'b0;
            REQ_UR_DISCARD <= 1'b0;
            UR_CPL_VALID   <= 1'b0;
            UR_CPL_TAG     <= `SCIR_TAG_RST;
            UR_CPL_DROPPED <= 1'b0;
        end else begin
            REQ_FORWARD    <= REQ_VALID && !is_ur;
            REQ_UR_DISCARD <= ur_event && REQ_POSTED;
            UR_CPL_DROPPED <= 1'b0;
            if (ur_np && (!UR_CPL_VALID || UR_CPL_READY)) begin
                UR_CPL_VALID <= 1'b1;
                UR_CPL_TAG   <= REQ_TAG;
            end else begin
                if (UR_CPL_READY)
                    UR_CPL_VALID <= 1'b0;
                // One-deep slot busy, completion is lost but status still set
                if (ur_np)
                    UR_CPL_DROPPED <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Error status and error message
    // ----------------------------------------
    reg err_pend_r;

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            UR_STATUS     <= 1'b0;
            ERR_MSG_VALID <= 1'b0;
            err_pend_r    <= 1'b0;
        end else begin
            // Set wins over clear
            if (ur_event)
                UR_STATUS <= 1'b1;
            else if (UR_STATUS_CLEAR)
                UR_STATUS <= 1'b0;
            if (ERR_MSG_VALID) begin
                if (ERR_MSG_READY) begin
                    ERR_MSG_VALID <= err_pend_r || ur_event;
                    err_pend_r    <= 1'b0;
                end else if (ur_event) begin
                    // Further errors merge into one pending message
                    err_pend_r <= 1'b1;
                end
            end else if (ur_event) begin
                ERR_MSG_VALID <= 1'b1;
            end
        end
    end
endmodule // scir_core

// *** sim/scir_core_monitor.sv ***
`timescale 1ns/1ps
`include "scir_consts.vh"
// ----------------------------------------
// Port checks
// ----------------------------------------
module scir_core_monitor (
    input wire logic       CLOCK,
    input wire logic       RESET_N,
    input wire logic [3:0] SWITCH_STATUS_UPSTREAM,
    input wire logic [3:0] IRQ_STATE_PORT_A,
    input wire logic [3:0] IRQ_STATE_PORT_B,
    input wire logic [3:0] IRQ_STATE_PORT_C,
    input wire logic       LINK_UP_B,
    input wire logic       IRQ_MSG_VALID,
    input wire logic       IRQ_MSG_ASSERT,
    input wire logic [1:0] IRQ_MSG_LINE,
    input wire logic       IRQ_MSG_READY,
    input wire logic       REQ_VALID,
    input wire logic [2:0] REQ_KIND,
    input wire logic       REQ_POSTED,
    input wire logic       REQ_FORWARD,
    input wire logic       REQ_UR_DISCARD,
    input wire logic       UR_CPL_VALID,
    input wire logic [7:0] UR_CPL_TAG,
    input wire logic       UR_CPL_READY,
    input wire logic       UR_CPL_DROPPED,
    input wire logic       UR_STATUS,
    input wire logic       ERR_MSG_VALID,
    input wire logic       ERR_MSG_READY
);
    wire [3:0] mapped = IRQ_STATE_PORT_B | {IRQ_STATE_PORT_C[2:0], IRQ_STATE_PORT_C[3]};
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    up_map_a: assert property (
        $stable(IRQ_STATE_PORT_B) && $stable(IRQ_STATE_PORT_C) |-> SWITCH_STATUS_UPSTREAM == mapped)
        else $error("upstream map mismatch");
    a_equal_a: assert property (
        IRQ_STATE_PORT_A == SWITCH_STATUS_UPSTREAM) else $error("port A state differs");
    link_clear_a: assert property (
        (!LINK_UP_B) [*4] |-> IRQ_STATE_PORT_B == 4'h0) else $error("link down state kept");
    assert_msg_a: assert property (
        $rose(SWITCH_STATUS_UPSTREAM[0]) |-> ##[1:40] ((IRQ_MSG_VALID && IRQ_MSG_ASSERT && IRQ_MSG_LINE == 2'd0)
        || !SWITCH_STATUS_UPSTREAM[0])) else $error("no assert message");
    deassert_msg_a: assert property (
        $fell(SWITCH_STATUS_UPSTREAM[3]) |-> ##[1:40] ((IRQ_MSG_VALID && !IRQ_MSG_ASSERT && IRQ_MSG_LINE == 2'd3)
        || SWITCH_STATUS_UPSTREAM[3])) else $error("no deassert message");
    cfg_zero_ur_a: assert property (
        REQ_VALID && REQ_KIND == `SCIR_K_CFG0 |=> !REQ_FORWARD && UR_STATUS) else $error("type 0 forwarded");
    posted_out_a: assert property (
        REQ_VALID && REQ_POSTED |=> REQ_FORWARD != REQ_UR_DISCARD) else $error("posted outcome wrong");
    cpl_hold_a: assert property (
        UR_CPL_VALID && !UR_CPL_READY |=> UR_CPL_VALID && $stable(UR_CPL_TAG)) else $error("completion lost");
    drop_status_a: assert property (
        UR_CPL_DROPPED |-> $past(UR_CPL_VALID) && $past(REQ_VALID) && UR_STATUS) else $error("bad drop");
    err_hold_a: assert property (
        ERR_MSG_VALID && !ERR_MSG_READY |=> ERR_MSG_VALID) else $error("error message dropped");
    cover property (IRQ_MSG_VALID && IRQ_MSG_READY && IRQ_MSG_ASSERT);
    cover property (UR_CPL_DROPPED);
    cover property (REQ_UR_DISCARD);
endmodule // scir_core_monitor
bind scir_core scir_core_monitor mon_u (.*);

// *** sim/scir_root_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Root side sink: pace 0 prompt, 1 slow, 2 stalled
// ----------------------------------------
module scir_root_model (
    input  wire logic [1:0] pace,
    input  wire logic       CLOCK,
    input  wire logic       RESET_N,
    output logic            IRQ_MSG_READY,
    output logic            UR_CPL_READY,
    output logic            ERR_MSG_READY
);
    logic [1:0] ph_r;
    logic       rdy_r;
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ph_r  <= 2'h0;
            rdy_r <= 1'b0;
        end else begin
            ph_r  <= ph_r + 2'h1;
            rdy_r <= (pace == 2'h0) || (pace == 2'h1 && ph_r == 2'h3);
        end
    end
    assign IRQ_MSG_READY = rdy_r;
    assign UR_CPL_READY  = rdy_r;
    assign ERR_MSG_READY = rdy_r;
endmodule // scir_root_model

// *** sim/scir_core_tb.sv ***
`timescale 1ns/1ps
`include "scir_consts.vh"
module scir_core_tb;
logic CLOCK, RESET_N, LINK_UP_B, LINK_UP_C, IRQ_MSG_READY, REQ_VALID, REQ_POSTED, REQ_TO_DOWNSTREAM, REQ_HIT_UP_WINDOW,
    REQ_HIT_DN_WINDOW, REQ_LEGACY_VIDEO_HIT, BRIDGE_INIT, MEMORY_ACCESS_ENABLE_B, IO_ACCESS_ENABLE_B,
    MEMORY_ACCESS_ENABLE_C, IO_ACCESS_ENABLE_C, LEGACY_VIDEO_DECODE_ENABLE_A, LEGACY_VIDEO_DECODE_ENABLE_B,
    LEGACY_VIDEO_DECODE_ENABLE_C, REQ_FORWARD, REQ_UR_DISCARD, UR_CPL_VALID, UR_CPL_READY, UR_CPL_DROPPED, UR_STATUS,
    UR_STATUS_CLEAR, ERR_MSG_VALID, ERR_MSG_READY, IRQ_MSG_VALID, IRQ_MSG_ASSERT;
logic [3:0] SWITCH_STATUS_UPSTREAM, IRQ_STATE_PORT_A, IRQ_STATE_PORT_B, IRQ_STATE_PORT_C, IRQ_PORT_B,
    IRQ_PORT_C_EXT, IRQ_NTB_INTERNAL;
logic [1:0] IRQ_MSG_LINE, REQ_DEST, pace;
logic [2:0] REQ_KIND;
logic [4:0] REQ_DEV_NUM;
logic [7:0] REQ_TAG, UR_CPL_TAG;
int         err_count, checks, n_as, n_de, n_err, n0;
scir_core dut_u (.*);
scir_root_model root_u (.*);
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
        err_count++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic results;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task automatic irq(input logic [3:0] b, c, n, pa, pb, pc);
    IRQ_PORT_B = b;
    IRQ_PORT_C_EXT = c;
    IRQ_NTB_INTERNAL = n;
    repeat (12) @(negedge CLOCK);
    chk(pa, SWITCH_STATUS_UPSTREAM);
    chk(pa, IRQ_STATE_PORT_A);
    chk(pb, IRQ_STATE_PORT_B);
    chk(pc, IRQ_STATE_PORT_C);
endtask
// Hit bits are to-downstream, upstream window, downstream window, video region
task automatic req(input logic [2:0] k, input logic p, input logic [1:0] d, input logic [4:0] dv,
                   input logic [3:0] hits, input logic ur);
    REQ_VALID = 1'b1;
    UR_STATUS_CLEAR = 1'b1;
    REQ_KIND = k;
    REQ_POSTED = p;
    REQ_DEST = d;
    REQ_DEV_NUM = dv;
    REQ_TAG = REQ_TAG + 8'h01;
    {REQ_TO_DOWNSTREAM, REQ_HIT_UP_WINDOW, REQ_HIT_DN_WINDOW, REQ_LEGACY_VIDEO_HIT} = hits;
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    UR_STATUS_CLEAR = 1'b0;
    chk(!ur, REQ_FORWARD);
    chk(ur & p, REQ_UR_DISCARD);
    chk(ur, UR_STATUS);
    chk(ur & !p, UR_CPL_VALID);
    if (ur & !p)
        chk(REQ_TAG, UR_CPL_TAG);
    @(negedge CLOCK);
endtask
// ----------------------------------------
// Clock, counters, watchdog
// ----------------------------------------
initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
end
always @(posedge CLOCK) begin
    if (IRQ_MSG_VALID === 1'b1 && IRQ_MSG_READY === 1'b1) begin
        if (IRQ_MSG_ASSERT === 1'b1)
            n_as++;
        else
            n_de++;
    end
    if (ERR_MSG_VALID === 1'b1 && ERR_MSG_READY === 1'b1)
        n_err++;
end
initial begin
    #200000;
    err_count++;
    results();
end
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    RESET_N = 1'b0;
    pace = 2'h0;
    {IRQ_PORT_B, IRQ_PORT_C_EXT, IRQ_NTB_INTERNAL, REQ_KIND, REQ_DEST, REQ_DEV_NUM, REQ_TAG} = 30'h0;
    {BRIDGE_INIT, MEMORY_ACCESS_ENABLE_B, IO_ACCESS_ENABLE_B, MEMORY_ACCESS_ENABLE_C, IO_ACCESS_ENABLE_C,
        LEGACY_VIDEO_DECODE_ENABLE_A, LINK_UP_B, LINK_UP_C} = 8'hff;
    {LEGACY_VIDEO_DECODE_ENABLE_B, LEGACY_VIDEO_DECODE_ENABLE_C, REQ_VALID, REQ_POSTED, REQ_TO_DOWNSTREAM,
        REQ_HIT_UP_WINDOW, REQ_HIT_DN_WINDOW, REQ_LEGACY_VIDEO_HIT, UR_STATUS_CLEAR} = 9'h0;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    RESET_N = 1'b1;
    @(negedge CLOCK);
    for (int p = 0; p < 2; p++) begin
        pace = p[1:0];
        for (int i = 0; i < 4; i++) begin
            irq(4'h1 << i, 4'h0, 4'h0, 4'h1 << i, 4'h1 << i, 4'h0);
            irq(4'h0, 4'h1 << i, 4'h0, 4'h1 << ((i + 1) % 4), 4'h0, 4'h1 << i);
            irq(4'h0, 4'h0, 4'h1 << i, 4'h1 << ((i + 1) % 4), 4'h0, 4'h1 << i);
            irq(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        end
    end
    irq(4'h1, 4'h8, 4'h0, 4'h1, 4'h1, 4'h8);
    irq(4'hf, 4'h0, 4'h0, 4'hf, 4'hf, 4'h0);
    LINK_UP_B = 1'b0;
    irq(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    LINK_UP_B = 1'b1;
    irq(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    chk(8'd20, n_as[7:0]);
    chk(8'd20, n_de[7:0]);
    pace = 2'h0;
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_B, 5'd0, 4'b0010, 1'b0);
    req(`SCIR_K_IO, 1'b1, `SCIR_DST_C, 5'd0, 4'b0010, 1'b0);
    req(`SCIR_K_CFG0, 1'b0, `SCIR_DST_B, 5'd0, 4'b0000, 1'b1);
    req(`SCIR_K_CFG1, 1'b0, `SCIR_DST_B, 5'd1, 4'b1000, 1'b1);
    req(`SCIR_K_CFG1, 1'b0, `SCIR_DST_B, 5'd0, 4'b1000, 1'b0);
    req(`SCIR_K_CFG1, 1'b0, `SCIR_DST_C, 5'd31, 4'b0000, 1'b0);
    req(`SCIR_K_MSG_ADDR, 1'b1, `SCIR_DST_B, 5'd0, 4'b0010, 1'b0);
    BRIDGE_INIT = 1'b0;
    req(`SCIR_K_MSG_ADDR, 1'b1, `SCIR_DST_B, 5'd0, 4'b0010, 1'b1);
    BRIDGE_INIT = 1'b1;
    req(`SCIR_K_MEM, 1'b1, `SCIR_DST_B, 5'd0, 4'b0100, 1'b1);
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_UP, 5'd0, 4'b0000, 1'b1);
    req(`SCIR_K_MSG_ID, 1'b0, `SCIR_DST_NONE, 5'd0, 4'b0000, 1'b1);
    MEMORY_ACCESS_ENABLE_C = 1'b0;
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_C, 5'd0, 4'b0010, 1'b1);
    MEMORY_ACCESS_ENABLE_C = 1'b1;
    IO_ACCESS_ENABLE_B = 1'b0;
    req(`SCIR_K_IO, 1'b0, `SCIR_DST_B, 5'd0, 4'b0010, 1'b1);
    IO_ACCESS_ENABLE_B = 1'b1;
    LINK_UP_C = 1'b0;
    repeat (4) @(negedge CLOCK);
    req(`SCIR_K_MEM, 1'b1, `SCIR_DST_C, 5'd0, 4'b0010, 1'b1);
    LINK_UP_C = 1'b1;
    repeat (4) @(negedge CLOCK);
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_B, 5'd0, 4'b0001, 1'b1);
    LEGACY_VIDEO_DECODE_ENABLE_C = 1'b1;
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_B, 5'd0, 4'b0001, 1'b0);
    LEGACY_VIDEO_DECODE_ENABLE_C = 1'b0;
    LEGACY_VIDEO_DECODE_ENABLE_A = 1'b0;
    req(`SCIR_K_MEM, 1'b0, `SCIR_DST_B, 5'd0, 4'b0001, 1'b0);
    pace = 2'h2;
    n0 = n_err;
    @(negedge CLOCK);
    {REQ_VALID, REQ_POSTED, REQ_KIND, REQ_TAG} = {1'b1, 1'b0, `SCIR_K_CFG0, 8'h41};
    @(negedge CLOCK);
    REQ_TAG = 8'h42;
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    chk(8'h01, UR_CPL_DROPPED);
    chk(8'h41, UR_CPL_TAG);
    chk(8'h01, ERR_MSG_VALID);
    pace = 2'h0;
    repeat (8) @(negedge CLOCK);
    chk(8'd2, 8'(n_err - n0));
    results();
end
endmodule // scir_core_tb
